// ===== src/tsf_device.sv
// Temperature sample queue with its register port.
`default_nettype none
module tsf_device
  import tsf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Conversion results
  input wire logic sample_valid_i,
  input wire logic [tsf_pkg::WORD_W-1:0] sample_data_i,
  // Register link
  tsf_link_if.device link
);
  import tsf_pkg::*;

  logic [WORD_W-1:0] mem [0:DEPTH-1];
  logic [PTR_W-1:0] push_pointer;
  logic [PTR_W-1:0] pop_pointer;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [4:0] lost_word_counter;
  logic [4:0] wmark_reg;
  logic rollover_enable;
  logic afull_type_reg;
  logic clear_on_data_read;
  logic afull_en_reg;
  logic [1:0] pin0_function_select;
  logic afull_reg;
  logic cond_reg;
  logic low_byte_reg;
  logic ack_reg;
  logic [7:0] rdata_reg;
  logic pin_reg;

  logic rd_acc;
  logic wr_acc;
  logic data_rd;
  logic status_rd;
  logic full;
  logic pop;
  logic push_store;
  logic lost;
  logic overwrite;
  logic flush;
  logic ptr_wr;
  logic [CNT_W-1:0] thresh;
  logic cond_next;
  logic afull_set;
  logic afull_clr;
  logic [7:0] rd_mux;
  logic [WORD_W-1:0] head_word;

  assign rd_acc = link.req && !link.we;
  assign wr_acc = link.req && link.we;
  assign data_rd = rd_acc && (link.addr == ADDR_DATA);
  assign status_rd = rd_acc && (link.addr == ADDR_STATUS);
  assign full = (count_reg == DEPTH_CNT);
  // A word leaves only when its second byte is read and it existed.
  assign pop = data_rd && low_byte_reg && (count_reg != '0);
  assign push_store = sample_valid_i && (!full || rollover_enable || pop);
  assign lost = sample_valid_i && full && !pop;
  assign overwrite = lost && rollover_enable;
  assign flush = wr_acc && (link.addr == ADDR_CFG2) &&
                 link.wdata[FLUSH_BIT];
  assign ptr_wr = wr_acc && (link.addr == ADDR_POP_PTR);

  tsf_ptr_counter u_push_ptr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(flush),
    .load_i(1'b0),
    .load_val_i(5'h00),
    .inc_i(push_store),
    .ptr_o(push_pointer)
  );

  // Rollover drags the read side along so the oldest word is dropped.
  tsf_ptr_counter u_pop_ptr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(flush),
    .load_i(ptr_wr),
    .load_val_i(link.wdata[PTR_W-1:0]),
    .inc_i(pop || overwrite),
    .ptr_o(pop_pointer)
  );

  always_ff @(posedge clk_i) begin
    if (push_store) begin
      mem[push_pointer] <= sample_data_i;
    end
  end

  always_comb begin
    count_next = count_reg;
    if (flush) begin
      count_next = '0;
    end else if (push_store && !pop && !full) begin
      count_next = count_reg + 6'h01;
    end else if (pop && !push_store) begin
      count_next = count_reg - 6'h01;
    end
    // Push with pop, or an overwrite when full, leaves it alone.
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || flush) begin
      lost_word_counter <= '0;
    end else if (pop) begin
      lost_word_counter <= '0;
    end else if (lost && lost_word_counter != LOST_MAX) begin
      lost_word_counter <= lost_word_counter + 5'h01;
    end
  end

  // Byte phase: any other access restarts the word at its upper byte.
  always_ff @(posedge clk_i) begin
    if (rst_i || flush) begin
      low_byte_reg <= 1'b0;
    end else if (data_rd) begin
      low_byte_reg <= !low_byte_reg;
    end else if (link.req) begin
      low_byte_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wmark_reg <= '0;
      rollover_enable <= 1'b0;
      afull_type_reg <= 1'b0;
      clear_on_data_read <= 1'b0;
      afull_en_reg <= 1'b0;
      pin0_function_select <= '0;
    end else if (wr_acc) begin
      unique case (link.addr)
        ADDR_WMARK: wmark_reg <= link.wdata[4:0];
        ADDR_CFG2: begin
          rollover_enable <= link.wdata[ROLLOVER_BIT];
          afull_type_reg <= link.wdata[AFULL_TYPE_BIT];
          clear_on_data_read <= link.wdata[CLR_DATA_BIT];
        end
        ADDR_INT_EN: afull_en_reg <= link.wdata[AFULL_BIT];
        ADDR_PIN_SETUP: pin0_function_select <= link.wdata[1:0];
        default: ;
      endcase
    end
  end

  // Almost-full detection against the stored word count.
  assign thresh = DEPTH_CNT - {1'b0, wmark_reg};
  assign cond_next = (count_next >= thresh);
  always_comb begin
    if (afull_type_reg) begin
      afull_set = cond_next && !cond_reg;
    end else begin
      afull_set = cond_next && sample_valid_i;
    end
  end
  assign afull_clr = status_rd || (data_rd && clear_on_data_read);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cond_reg <= 1'b0;
      afull_reg <= 1'b0;
    end else begin
      cond_reg <= cond_next;
      // A fresh condition in the clearing cycle is kept, not lost.
      if (afull_set) begin
        afull_reg <= 1'b1;
      end else if (afull_clr) begin
        afull_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= afull_reg && afull_en_reg &&
                 (pin0_function_select == PIN_MODE_INT);
    end
  end

  assign head_word = mem[pop_pointer];
  always_comb begin
    rd_mux = BYTE_RST;
    unique case (link.addr)
      ADDR_STATUS: rd_mux = {afull_reg, 7'h00};
      ADDR_INT_EN: rd_mux = {afull_en_reg, 7'h00};
      ADDR_PUSH_PTR: rd_mux = {3'h0, push_pointer};
      ADDR_POP_PTR: rd_mux = {3'h0, pop_pointer};
      ADDR_LOST: rd_mux = {3'h0, lost_word_counter};
      ADDR_AVAIL: rd_mux = {2'h0, count_reg};
      ADDR_DATA: begin
        // An empty queue still answers, with the byte under the pointer.
        rd_mux = low_byte_reg ? head_word[7:0] : head_word[15:8];
      end
      ADDR_WMARK: rd_mux = {3'h0, wmark_reg};
      ADDR_CFG2: rd_mux = {4'h0, clear_on_data_read, afull_type_reg,
                           rollover_enable, 1'b0};
      ADDR_PIN_SETUP: rd_mux = {6'h00, pin0_function_select};
      default: rd_mux = BYTE_RST;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= BYTE_RST;
    end else begin
      ack_reg <= link.req;
      if (rd_acc) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign link.ack = ack_reg;
  assign link.rdata = rdata_reg;
  assign link.general_pin_zero = pin_reg;
endmodule : tsf_device
`default_nettype wire

// ===== src/tsf_host.sv
// Link controller driven by software over classic Wishbone.
`default_nettype none
module tsf_host
  import tsf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq_o,
  // Register link
  tsf_link_if.host link
);
  import tsf_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } tsf_state_type;

  tsf_state_type state_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic we_reg;
  logic req_reg;
  logic [7:0] result_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_stat_next;
  logic [1:0] irq_mask_reg;
  logic pin_prev_reg;
  logic acc;
  logic wr;
  logic go;
  logic done;
  logic busy;
  logic [1:0] events;

  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i;
  assign busy = (state_reg == ST_WAIT);
  // A start while a transfer is open is dropped: one request at a time.
  assign go = wr && (wb_adr_i == WB_CMD) && wb_sel_i[3] &&
              wb_dat_i[GO_BIT] && !busy;
  assign done = busy && link.ack;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_reg <= BYTE_RST;
      wdata_reg <= BYTE_RST;
      we_reg <= 1'b0;
    end else if (wr && (wb_adr_i == WB_CMD) && !busy) begin
      if (wb_sel_i[0]) begin
        addr_reg <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        wdata_reg <= wb_dat_i[15:8];
      end
      if (wb_sel_i[2]) begin
        we_reg <= wb_dat_i[16];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      req_reg <= 1'b0;
      result_reg <= BYTE_RST;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (go) begin
            req_reg <= 1'b1;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          req_reg <= 1'b0;
          if (link.ack) begin
            result_reg <= link.rdata;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign events[IRQ_DONE_BIT] = done;
  assign events[IRQ_PIN_BIT] = link.general_pin_zero && !pin_prev_reg;

  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (acc && !wb_we_i && (wb_adr_i == WB_IRQ_STAT)) begin
      irq_stat_next = IRQ_RST;
    end
    // An event in the clearing cycle survives the read.
    irq_stat_next = irq_stat_next | events;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= IRQ_RST;
      irq_mask_reg <= IRQ_RST;
      pin_prev_reg <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      pin_prev_reg <= link.general_pin_zero;
      if (wr && (wb_adr_i == WB_IRQ_MASK) && wb_sel_i[0]) begin
        irq_mask_reg <= wb_dat_i[1:0];
      end
      irq_o <= |(irq_stat_next & irq_mask_reg);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        unique case (wb_adr_i)
          WB_CMD: wb_dat_o <= {7'h00, busy, 7'h00, we_reg,
                               wdata_reg, addr_reg};
          WB_RESULT: wb_dat_o <= {23'h000000, busy, result_reg};
          WB_IRQ_STAT: wb_dat_o <= {30'h00000000, irq_stat_reg};
          WB_IRQ_MASK: wb_dat_o <= {30'h00000000, irq_mask_reg};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  assign link.req = req_reg;
  assign link.we = we_reg;
  assign link.addr = addr_reg;
  assign link.wdata = wdata_reg;
endmodule : tsf_host
`default_nettype wire

// ===== src/tsf_link_if.sv
// Register link between the queue device and its controller.
`default_nettype none
interface tsf_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic general_pin_zero;
  modport device(input req, input we, input addr, input wdata,
                 output ack, output rdata, output general_pin_zero);
  modport host(output req, output we, output addr, output wdata,
               input ack, input rdata, input general_pin_zero);
endinterface : tsf_link_if
`default_nettype wire

// ===== src/tsf_pkg.sv
// Shared constants for the temperature sample queue and its controller.
// Operation
// - Count lost words, saturating at 0x1F.
// - Completed word pop zeroes the lost counter.
// - Master reads lost counter right before data.
// - Six-bit available count tracks pushes and pops.
// - Data byte register; 2N bytes give N words.
// - Upper byte first, then lower byte.
// - Nonzero lost count means assume 32 words.
// - Equal pointers: count tells empty from full.
// - Almost-full sets at 32 minus watermark words.
// - Flag, enable and pin mode drive pin.
// - Full queue: rollover overwrites, else discard.
// - Type low: flag reasserts on every sample.
// - Type high: flag sets on fresh condition.
// - Option high: data read also clears flag.
// - Flush zeroes pointers and counts, self-clears.
// - Storage for 32 sixteen-bit samples.
// - Five-bit pointers wrap 0x1f to 0x00.
// - Master may write the read pointer.
`default_nettype none
package tsf_pkg;
  localparam int WORD_W = 16;
  localparam int DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam int BYTE_W = 8;
  localparam logic [4:0] LOST_MAX = 5'h1f;
  localparam logic [5:0] DEPTH_CNT = 6'h20;
  // Device register offsets.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_INT_EN = 8'h01;
  localparam logic [7:0] ADDR_PUSH_PTR = 8'h04;
  localparam logic [7:0] ADDR_POP_PTR = 8'h05;
  localparam logic [7:0] ADDR_LOST = 8'h06;
  localparam logic [7:0] ADDR_AVAIL = 8'h07;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_WMARK = 8'h09;
  localparam logic [7:0] ADDR_CFG2 = 8'h0a;
  localparam logic [7:0] ADDR_PIN_SETUP = 8'h20;
  // Field positions.
  localparam int AFULL_BIT = 7;
  localparam int FLUSH_BIT = 4;
  localparam int CLR_DATA_BIT = 3;
  localparam int AFULL_TYPE_BIT = 2;
  localparam int ROLLOVER_BIT = 1;
  localparam logic [1:0] PIN_MODE_INT = 2'h3;
  // Controller Wishbone word offsets (byte addresses).
  localparam logic [3:0] WB_CMD = 4'h0;
  localparam logic [3:0] WB_RESULT = 4'h4;
  localparam logic [3:0] WB_IRQ_STAT = 4'h8;
  localparam logic [3:0] WB_IRQ_MASK = 4'hc;
  localparam int GO_BIT = 24;
  localparam int BUSY_BIT = 8;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_PIN_BIT = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
endpackage : tsf_pkg
`default_nettype wire

// ===== src/tsf_ptr_counter.sv
// Wrapping queue pointer with clear, load and advance.
`default_nettype none
module tsf_ptr_counter
  import tsf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [tsf_pkg::PTR_W-1:0] load_val_i,
  input wire logic inc_i,
  // Value
  output logic [tsf_pkg::PTR_W-1:0] ptr_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      ptr_o <= '0;
    end else if (load_i) begin
      ptr_o <= load_val_i;
    end else if (inc_i) begin
      ptr_o <= ptr_o + 5'h01;
    end
  end
endmodule : tsf_ptr_counter
`default_nettype wire

// ===== tb/tb_top.sv
// Bench driving the controller over Wishbone and samples into the queue.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tsf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic sv = 1'b0;
  logic fire = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] dat_o;
  logic [15:0] sd = 16'h0;
  logic ack_o;
  logic irq;
  int n_mismatch = 0;
  int samples_checked = 0;
  tsf_link_if link_bus ();
  tsf_device u_tsf_device (.clk_i(clk_i), .rst_i(rst_i),
    .sample_valid_i(sv), .sample_data_i(sd), .link(link_bus));
  tsf_host u_tsf_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack_o), .irq_o(irq),
    .link(link_bus));
  tsf_link_monitor u_tsf_link_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .req(link_bus.req), .we(link_bus.we), .addr(link_bus.addr),
    .wdata(link_bus.wdata), .ack(link_bus.ack), .rdata(link_bus.rdata),
    .general_pin_zero(link_bus.general_pin_zero));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // The sample strobe can ride along the command so that a push lands on
  // the very edge where the device takes the link request.
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    @(posedge clk_i);
    if (fire) begin
      sv <= 1'b1;
    end
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_mismatch++;
        tally_and_finish();
      end
      @(posedge clk_i);
    end
    r = dat_o;
    {cyc, stb, sv} <= 3'b000;
    fire = 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic dev(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    logic [31:0] t;
    int n;
    n = 0;
    wb(1'b1, WB_CMD, {7'h00, 1'b1, 7'h00, w, d, a}, t);
    t = 32'h100;
    while (t[BUSY_BIT] !== 1'b0) begin
      n++;
      if (n > 20) begin
        n_mismatch++;
        tally_and_finish();
      end
      wb(1'b0, WB_RESULT, 32'h0, t);
    end
    r = t[7:0];
  endtask : dev
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string nm);
    logic [7:0] r;
    dev(1'b0, a, 8'h00, r);
    chk(nm, {24'h0, e}, {24'h0, r});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    dev(1'b1, a, d, r);
  endtask : wr
  function automatic logic [15:0] wv(input int i);
    return {8'h80 | i[7:0], 8'h11 + i[7:0]};
  endfunction : wv
  task automatic push(input int k, input int s);
    sv <= 1'b1;
    for (int i = 0; i < k; i++) begin
      sd <= wv(s + i);
      @(posedge clk_i);
    end
    sv <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : push
  task automatic pop(input int i);
    logic [15:0] w;
    w = wv(i);
    rd(ADDR_DATA, w[15:8], "upper byte");
    rd(ADDR_DATA, w[7:0], "lower byte");
  endtask : pop
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_AVAIL, 8'h00, "count");
    rd(ADDR_LOST, 8'h00, "lost");
    rd(8'h30, 8'h00, "unmapped");
    wr(ADDR_PUSH_PTR, 8'h07);
    rd(ADDR_PUSH_PTR, 8'h00, "push ptr");
    wb(1'b1, WB_IRQ_MASK, 32'h1, q);
    rd(ADDR_STATUS, 8'h00, "status");
    chk("irq out", 32'h1, {31'h0, irq});
    wb(1'b0, WB_IRQ_STAT, 32'h0, q);
    chk("irq stat", 32'h1, q);
    chk("irq out", 32'h0, {31'h0, irq});
    wb(1'b1, WB_IRQ_MASK, 32'h2, q);
    $display("test reset and irq done");
    wr(ADDR_CFG2, 8'h10);
    push(3, 0);
    rd(ADDR_AVAIL, 8'h03, "count");
    rd(ADDR_DATA, 8'h80, "upper byte");
    sd <= wv(3);
    fire = 1'b1;
    rd(ADDR_DATA, 8'h11, "lower byte");
    rd(ADDR_AVAIL, 8'h03, "count");
    rd(ADDR_POP_PTR, 8'h01, "pop ptr");
    rd(ADDR_PUSH_PTR, 8'h04, "push ptr");
    wr(ADDR_POP_PTR, 8'h00);
    pop(0);
    chk("irq out", 32'h0, {31'h0, irq});
    $display("test push pop done");
    wr(ADDR_CFG2, 8'h10);
    rd(ADDR_POP_PTR, 8'h00, "pop ptr");
    rd(ADDR_CFG2, 8'h00, "config");
    push(34, 0);
    rd(ADDR_AVAIL, 8'h20, "count");
    rd(ADDR_PUSH_PTR, 8'h00, "push ptr");
    rd(ADDR_LOST, 8'h02, "lost");
    pop(0);
    rd(ADDR_LOST, 8'h00, "lost");
    push(41, 40);
    rd(ADDR_LOST, 8'h1f, "lost");
    wr(ADDR_CFG2, 8'h12);
    push(33, 0);
    rd(ADDR_AVAIL, 8'h20, "count");
    pop(1);
    $display("test full queue done");
    wr(ADDR_CFG2, 8'h10);
    // The flag from the full runs survives data reads and the flush.
    rd(ADDR_STATUS, 8'h80, "status");
    wr(ADDR_WMARK, 8'h02);
    rd(ADDR_WMARK, 8'h02, "watermark");
    wr(ADDR_INT_EN, 8'h80);
    wr(ADDR_PIN_SETUP, 8'h03);
    wb(1'b0, WB_CMD, 32'h0, q);
    chk("cmd", 32'h00010320, q);
    push(29, 0);
    rd(ADDR_STATUS, 8'h00, "status");
    push(1, 29);
    chk("pin", 32'h1, {31'h0, link_bus.general_pin_zero});
    chk("irq out", 32'h1, {31'h0, irq});
    wb(1'b0, WB_IRQ_STAT, 32'h0, q);
    chk("irq stat", 32'h3, q);
    rd(ADDR_STATUS, 8'h80, "status");
    rd(ADDR_STATUS, 8'h00, "status");
    push(1, 30);
    rd(ADDR_STATUS, 8'h80, "status");
    wr(ADDR_CFG2, 8'h04);
    push(1, 31);
    rd(ADDR_STATUS, 8'h00, "status");
    wr(ADDR_CFG2, 8'h1c);
    rd(ADDR_CFG2, 8'h0c, "config");
    push(30, 0);
    chk("pin", 32'h1, {31'h0, link_bus.general_pin_zero});
    rd(ADDR_DATA, 8'h80, "upper byte");
    rd(ADDR_STATUS, 8'h00, "status");
    $display("test almost full done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire

// ===== tb/tsf_link_monitor.sv
// Protocol and register-value checks on the queue register link.
`default_nettype none
module tsf_link_monitor
  import tsf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic general_pin_zero
);
  logic rd_ack;
  assign rd_ack = ack & ~we;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_after_req_a: assert property (req |=> ack)
    else $error("link ack missing after request");
  ack_has_cause_a: assert property (ack |-> $past(req))
    else $error("link ack without request");
  ack_one_cycle_a: assert property (ack |=> !ack)
    else $error("link ack longer than one cycle");
  req_spacing_a: assert property (req |=> !req [*2])
    else $error("link requests too close");
  req_held_a: assert property (req |=> $stable({we, addr, wdata}))
    else $error("link request fields moved before ack");
  rdata_hold_a: assert property ($changed(rdata) |-> rd_ack)
    else $error("read byte changed outside a read answer");
  lost_saturates_a: assert property (rd_ack && addr == ADDR_LOST
    |-> rdata <= 8'h1f)
    else $error("lost count above saturation");
  count_range_a: assert property (rd_ack && addr == ADDR_AVAIL
    |-> rdata <= 8'h20)
    else $error("available count above depth");
  ptr_width_a: assert property (rd_ack &&
    (addr == ADDR_PUSH_PTR || addr == ADDR_POP_PTR) |-> rdata[7:5] == 3'h0)
    else $error("pointer wider than five bits");
  flush_clears_a: assert property (rd_ack && addr == ADDR_CFG2
    |-> !rdata[FLUSH_BIT])
    else $error("flush bit did not clear itself");
  pin_fall_cause_a: assert property ($fell(general_pin_zero)
    |-> $past(req, 2))
    else $error("pin dropped without a register access");
endmodule : tsf_link_monitor
`default_nettype wire
